// File: verilog/rtcsp_pkg.sv
// constants for the serial port slave of the real time clock
// assumes one 20 MHz system clock samples every pin of the serial link
//
// How it works
// - select pin high four-wire, low three-wire
// - select low resets transfer, output released
// - clock level at select rise is idle
// - four-wire: latch strobe edge, shift opposite
// - output released until read byte ready
// - four-wire bytes travel most significant first
// - first byte is address, then data
// - direction bit zero reads, one writes
// - pointer advances after every data byte
// - clock range wraps 1Fh-00h, 9Fh-80h
// - RAM range wraps 7Fh-20h, FFh-A0h
// - three-wire: one data line, LSB first
// - three-wire: sample rising, drive falling
// - primary below battery rejects all writes unless backup is rechargeable
// - rechargeable backup never blocks writes
// - write lock blocks writes except lock bit
// - read address top clear, write set
`default_nettype none
package rtcsp_pkg;
   // ----------------------------------------------------------------
   // byte and address layout
   // ----------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 8;
   localparam int DIR_BIT = 7;
   localparam int LOCK_BIT = 6;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [7:0] CLK_RD_FIRST = 8'h00;
   localparam logic [7:0] CLK_RD_LAST = 8'h1F;
   localparam logic [7:0] RAM_RD_FIRST = 8'h20;
   localparam logic [7:0] RAM_RD_LAST = 8'h7F;
   localparam logic [7:0] CLK_WR_FIRST = 8'h80;
   localparam logic [7:0] CLK_WR_LAST = 8'h9F;
   localparam logic [7:0] RAM_WR_FIRST = 8'hA0;
   localparam logic [7:0] RAM_WR_LAST = 8'hFF;
   localparam logic [7:0] CTRL_WR_ADDR = 8'h8F;
   localparam logic [7:0] PTR_RESET = 8'h00;
   // ----------------------------------------------------------------
   // write queue and pin sampling
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 8;
   localparam int WQ_W = ADDR_W + BYTE_W + 1;
   localparam int PIN_CE = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_DIN = 2;
   localparam int PIN_MODE = 3;
   localparam int PIN_LOWSUP = 4;
   localparam int PIN_RECHG = 5;
   localparam int PIN_COUNT = 6;
   typedef enum logic [1:0] {PH_ADDR, PH_READ, PH_WRITE} rtcsp_phase_e;
endpackage : rtcsp_pkg
`default_nettype wire

// File: verilog/rtcsp_serial_port.sv
// serial port slave: address decode, burst pointer, write queue, read shifter
// assumes location storage outside answers rdAddr within one clock and
// drains the write queue; link pins are asynchronous to clk
`default_nettype none
`timescale 1ns/1ps

// --------------------------------------------------------------------
// write queue
// --------------------------------------------------------------------
module rtcsp_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic clk,                 // system clock
   input wire logic rstN,                // synchronised reset, low active
   input wire logic inValid,             // push request
   input wire logic [WIDTH-1:0] inData,  // pushed word
   output logic inReady,                 // room for a word
   output logic outValid,                // word available
   output logic [WIDTH-1:0] outData,     // oldest word
   input wire logic outReady             // consumer takes word
);
   // depth must be a power of two: pointers wrap naturally
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   assign empty = (wrPtr == rdPtr);
   assign push = inValid && !full;
   assign pop = outReady && !empty;
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[rdPtr[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrPtr <= '0;
      end
      else if (push)
      begin
         wrPtr <= wrPtr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         rdPtr <= '0;
      end
      else if (pop)
      begin
         rdPtr <= rdPtr + 1'b1;
      end
   end
endmodule : rtcsp_fifo

// --------------------------------------------------------------------
// serial port top
// --------------------------------------------------------------------
module rtcsp_serial_port #(
   parameter int QUEUE_DEPTH = rtcsp_pkg::FIFO_DEPTH
) (
   input wire logic clk,                                // 20 MHz system clock
   input wire logic rst_n,                              // async reset, low active
   input wire logic selectIn,                           // chip enable pin, high active
   input wire logic sclkIn,                             // serial clock pin
   input wire logic serialIn,                           // data in pin, or shared line in
   output logic serialOut,                              // data out value
   output logic serialOutEn,                            // data out drive enable
   input wire logic interfaceSelectPin,                 // high four-wire, low three-wire
   input wire logic primaryBelowBattery,                // supply comparator flag
   input wire logic rechargeableBackup,                 // strap: backup is rechargeable
   input wire logic writeLock,                          // lock bit of control register
   output logic [rtcsp_pkg::ADDR_W-1:0] rdAddr,         // location to read
   input wire logic [rtcsp_pkg::BYTE_W-1:0] rdData,     // contents of rdAddr
   output logic wrValid,                                // queued write pending
   output logic [rtcsp_pkg::ADDR_W-1:0] wrAddr,         // write location
   output logic [rtcsp_pkg::BYTE_W-1:0] wrData,         // write value
   output logic wrLockOnly,                             // apply lock bit only
   input wire logic wrReady,                            // storage takes write
   output logic writeDropped,                           // queue overflow this transfer
   output logic transferActive                          // select seen high
);
   import rtcsp_pkg::*;

   // -----------------------------------------------------------------
   // reset release and pin synchronisers
   // -----------------------------------------------------------------
   logic rstMeta;
   logic rstN;
   logic [PIN_COUNT-1:0] pinRaw;
   logic [PIN_COUNT-1:0] pinMeta;
   logic [PIN_COUNT-1:0] pinSync;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   assign pinRaw[PIN_CE] = selectIn;
   assign pinRaw[PIN_SCLK] = sclkIn;
   assign pinRaw[PIN_DIN] = serialIn;
   assign pinRaw[PIN_MODE] = interfaceSelectPin;
   assign pinRaw[PIN_LOWSUP] = primaryBelowBattery;
   assign pinRaw[PIN_RECHG] = rechargeableBackup;

   for (genvar i = 0; i < PIN_COUNT; i++)
   begin : gSync
      always_ff @(posedge clk or negedge rstN)
      begin
         if (!rstN)
         begin
            pinMeta[i] <= 1'b0;
            pinSync[i] <= 1'b0;
         end
         else
         begin
            pinMeta[i] <= pinRaw[i];
            pinSync[i] <= pinMeta[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // select and clock edge detection
   // -----------------------------------------------------------------
   logic sel;
   logic cePrev;
   logic sclkPrev;
   logic ceRise;
   logic active;
   logic sclkRise;
   logic sclkFall;
   logic idleLevel;
   logic fourWire;
   logic latchEdge;
   logic shiftEdge;

   assign sel = pinSync[PIN_CE];
   assign ceRise = sel && !cePrev;
   // the rise cycle itself only captures polarity and mode and clears writeDropped
   assign active = sel && cePrev;
   assign sclkRise = pinSync[PIN_SCLK] && !sclkPrev;
   assign sclkFall = !pinSync[PIN_SCLK] && sclkPrev;
   assign transferActive = sel;

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         cePrev <= 1'b0;
         sclkPrev <= 1'b0;
      end
      else
      begin
         cePrev <= sel;
         sclkPrev <= pinSync[PIN_SCLK];
      end
   end

   // mode held for the whole transfer so a pin glitch cannot split a byte
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         idleLevel <= 1'b0;
         fourWire <= 1'b0;
      end
      else if (ceRise)
      begin
         idleLevel <= pinSync[PIN_SCLK];
         fourWire <= pinSync[PIN_MODE];
      end
   end

   // four-wire: shift edge leaves idle, strobe edge returns to it
   assign latchEdge = active && (fourWire ? (idleLevel ? sclkRise : sclkFall)
                                          : sclkRise);
   assign shiftEdge = active && (fourWire ? (idleLevel ? sclkFall : sclkRise)
                                          : sclkFall);

   // -----------------------------------------------------------------
   // receive shifter
   // -----------------------------------------------------------------
   logic [BYTE_W-1:0] rxShift;
   logic [BYTE_W-1:0] rxNext;
   logic [2:0] bitCnt;
   logic byteDone;

   always_comb
   begin
      if (fourWire)
      begin
         rxNext = {rxShift[BYTE_W-2:0], pinSync[PIN_DIN]};
      end
      else
      begin
         rxNext = {pinSync[PIN_DIN], rxShift[BYTE_W-1:1]};
      end
   end

   assign byteDone = latchEdge && (bitCnt == LAST_BIT);

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         rxShift <= '0;
         bitCnt <= '0;
      end
      else if (!sel)
      begin
         rxShift <= '0;
         bitCnt <= '0;
      end
      else if (latchEdge)
      begin
         rxShift <= rxNext;
         bitCnt <= bitCnt + 3'h1;
      end
   end

   // -----------------------------------------------------------------
   // phase and location pointer
   // -----------------------------------------------------------------
   rtcsp_phase_e phase;
   logic [ADDR_W-1:0] ptr;
   logic [ADDR_W-1:0] ptrAdv;

   function automatic logic [ADDR_W-1:0] advance(input logic [ADDR_W-1:0] p);
      logic [ADDR_W-1:0] r;
      r = p + 8'h01;
      case (p)
         CLK_RD_LAST: r = CLK_RD_FIRST;
         CLK_WR_LAST: r = CLK_WR_FIRST;
         RAM_RD_LAST: r = RAM_RD_FIRST;
         RAM_WR_LAST: r = RAM_WR_FIRST;
         default: r = p + 8'h01;
      endcase
      return r;
   endfunction : advance

   assign ptrAdv = advance(ptr);

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         phase <= PH_ADDR;
      end
      else if (!sel)
      begin
         phase <= PH_ADDR;
      end
      else if (byteDone)
      begin
         case (phase)
            PH_ADDR: phase <= rxNext[DIR_BIT] ? PH_WRITE : PH_READ;
            PH_READ: phase <= PH_READ;
            PH_WRITE: phase <= PH_WRITE;
            default: phase <= PH_ADDR;
         endcase
      end
   end

   // top bit kept in the pointer: read and write ranges stay apart
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         ptr <= PTR_RESET;
      end
      else if (byteDone)
      begin
         if (phase == PH_ADDR)
         begin
            ptr <= rxNext;
         end
         else
         begin
            ptr <= ptrAdv;
         end
      end
   end

   // -----------------------------------------------------------------
   // read fetch and transmit shifter
   // -----------------------------------------------------------------
   logic rdEvent;
   logic [1:0] loadPipe;
   logic outEn;
   logic [BYTE_W-1:0] txShift;

   assign rdEvent = byteDone && ((phase == PH_READ) ||
                                 ((phase == PH_ADDR) && !rxNext[DIR_BIT]));

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         rdAddr <= PTR_RESET;
      end
      else if (rdEvent)
      begin
         rdAddr <= (phase == PH_ADDR) ? rxNext : ptrAdv;
      end
   end

   // two cycles leave rdData two clocks to settle; half a link period is four
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         loadPipe <= '0;
      end
      else if (!sel)
      begin
         loadPipe <= '0;
      end
      else
      begin
         loadPipe <= {loadPipe[0], rdEvent};
      end
   end

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         txShift <= '0;
         serialOut <= 1'b0;
         outEn <= 1'b0;
      end
      else if (!sel)
      begin
         txShift <= '0;
         serialOut <= 1'b0;
         outEn <= 1'b0;
      end
      else if (loadPipe[1])
      begin
         txShift <= rdData;
         outEn <= 1'b1;
      end
      else if (shiftEdge && outEn)
      begin
         if (fourWire)
         begin
            serialOut <= txShift[BYTE_W-1];
            txShift <= {txShift[BYTE_W-2:0], 1'b0};
         end
         else
         begin
            serialOut <= txShift[0];
            txShift <= {1'b0, txShift[BYTE_W-1:1]};
         end
      end
   end

   assign serialOutEn = outEn && sel;

   // -----------------------------------------------------------------
   // write acceptance and queue
   // -----------------------------------------------------------------
   logic supplyBlock;
   logic lockPass;
   logic pushValid;
   logic pushReady;
   logic [WQ_W-1:0] pushWord;
   logic [WQ_W-1:0] popWord;

   // rechargeable backup strap disables the supply based block
   assign supplyBlock = pinSync[PIN_LOWSUP] && !pinSync[PIN_RECHG];
   // under lock only the control location passes, narrowed to its lock bit
   assign lockPass = !writeLock || (ptr == CTRL_WR_ADDR);
   assign pushValid = byteDone && (phase == PH_WRITE) && !supplyBlock && lockPass;
   assign pushWord = {ptr, rxNext, writeLock};

   rtcsp_fifo #(
      .WIDTH(WQ_W),
      .DEPTH(QUEUE_DEPTH)
   ) uQueue (
      .clk(clk),
      .rstN(rstN),
      .inValid(pushValid),
      .inData(pushWord),
      .inReady(pushReady),
      .outValid(wrValid),
      .outData(popWord),
      .outReady(wrReady)
   );

   assign wrAddr = popWord[WQ_W-1 -: ADDR_W];
   assign wrData = popWord[BYTE_W:1];
   assign wrLockOnly = popWord[0];

   // the master cannot be stalled, so a full queue can only be reported
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         writeDropped <= 1'b0;
      end
      else if (pushValid && !pushReady)
      begin
         writeDropped <= 1'b1;
      end
      else if (ceRise)
      begin
         writeDropped <= 1'b0;
      end
   end
endmodule : rtcsp_serial_port
`default_nettype wire

// File: dv/rtcsp_chk.sv
// port checker for the serial port slave
// assumes it is bound into rtcsp_serial_port
`default_nettype none
`timescale 1ns/1ps
module rtcsp_chk (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset
   input wire logic selectIn, // select pin
   input wire logic serialOutEn, // out enable
   input wire logic transferActive, // synced select
   input wire logic [rtcsp_pkg::ADDR_W-1:0] rdAddr, // read location
   input wire logic wrValid, // write pending
   input wire logic wrReady, // storage takes
   input wire logic [rtcsp_pkg::ADDR_W-1:0] wrAddr, // write location
   input wire logic [rtcsp_pkg::BYTE_W-1:0] wrData, // write value
   input wire logic wrLockOnly, // lock bit only
   input wire logic primaryBelowBattery, // supply flag
   input wire logic rechargeableBackup // backup strap
);
   import rtcsp_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   function automatic logic [7:0] nxt(input logic [7:0] p);
      case (p)
         CLK_RD_LAST: return CLK_RD_FIRST;
         RAM_RD_LAST: return RAM_RD_FIRST;
         default: return p + 8'h01;
      endcase
   endfunction : nxt
   sequence s_selRise;
      $rose(transferActive);
   endsequence
   sequence s_quiet;
      !serialOutEn [*8];
   endsequence
   chk_en_in_sel: assert property (serialOutEn |-> transferActive)
      else $error("out enabled outside transfer");
   chk_sel_release: assert property (!selectIn [*4] |-> !serialOutEn && !transferActive)
      else $error("select low, port active");
   chk_addr_first: assert property (s_selRise |-> s_quiet)
      else $error("out enabled in address byte");
   chk_rd_step: assert property ($changed(rdAddr) && $past(serialOutEn)
      |-> rdAddr == nxt($past(rdAddr)))
      else $error("read pointer step wrong");
   chk_rd_top: assert property (!rdAddr[DIR_BIT])
      else $error("read location top bit set");
   chk_wr_top: assert property (wrValid |-> wrAddr[DIR_BIT])
      else $error("write location top bit clear");
   chk_lock_only: assert property (wrValid && wrLockOnly |-> wrAddr == CTRL_WR_ADDR)
      else $error("locked write not control");
   chk_supply_block: assert property ($rose(wrValid)
      |-> !($past(primaryBelowBattery, 3) && !$past(rechargeableBackup, 3)))
      else $error("write passed on low supply");
   chk_head_hold: assert property (wrValid && !wrReady
      |=> wrValid && $stable(wrAddr) && $stable(wrData))
      else $error("queue head moved unpopped");
endmodule : rtcsp_chk
bind rtcsp_serial_port rtcsp_chk i_chk (.clk, .rst_n, .selectIn, .serialOutEn,
   .transferActive, .rdAddr, .wrValid, .wrReady, .wrAddr, .wrData, .wrLockOnly,
   .primaryBelowBattery, .rechargeableBackup);
`default_nettype wire

// File: dv/rtcsp_master.sv
// link master model: select, link clock, data line
// assumes the bench fills tx before frame and reads rx after
`default_nettype none
`timescale 1ns/1ps
module rtcsp_master (
   input wire logic clk, // paces the link
   input wire logic threeWire, // shared data line
   input wire logic dutOut, // device data out
   input wire logic dutEn, // device drive enable
   output logic sel, // select pin
   output logic sck, // link clock pin
   output logic serial_in // device data in pin
);
   logic [7:0] tx[$];
   logic [7:0] rx[$];
   logic mOut = 1'b0;
   logic mEn = 1'b0;
   logic junk = 1'b0;
   logic miso;
   // no pull on the line: a released line shows noise
   always @(negedge clk) junk <= ~junk;
   assign serial_in = mEn ? mOut : (threeWire && dutEn) ? dutOut : junk;
   assign miso = dutEn ? dutOut : junk;
   initial
   begin
      sel = 1'b0;
      sck = 1'b0;
   end
   task automatic half(input int n);
      repeat (4 * n) @(negedge clk);
   endtask : half
   // ------
   // one transfer of nb bits
   // ------
   task automatic frame(input logic pol, input int nb);
      int i;
      logic rd;
      logic [7:0] sh;
      rd = !tx[0][7];
      rx.delete();
      sck = pol;
      half(2);
      sel = 1'b1;
      half(2);
      for (i = 0; i < nb; i++)
      begin
         // three-wire sets up ahead of the rising sample edge
         if (threeWire)
         begin
            mOut = tx[i / 8][i % 8];
            mEn = i < 8 || !rd;
         end
         half(1);
         if (threeWire && i >= 8) sh = {miso, sh[7:1]};
         sck = ~pol;
         // four-wire shifts on the leading edge so data holds past the strobe edge
         if (!threeWire)
         begin
            mOut = tx[i / 8][7 - i % 8];
            mEn = i < 8 || !rd;
         end
         half(1);
         if (!threeWire && i >= 8) sh = {sh[6:0], miso};
         sck = pol;
         if (rd && i >= 8 && i % 8 == 7) rx.push_back(sh);
      end
      // last bit stays driven for a half period past a four-wire strobe edge, a full period past the three-wire rising edge
      half(1);
      mEn = 1'b0;
      sel = 1'b0;
      half(2);
   endtask : frame
endmodule : rtcsp_master
`default_nettype wire

// File: dv/rtc_serial_port_slave_bench.sv
// bench for the serial port slave, one task per scenario
// assumes rtcsp_master drives the link; the bench is storage
`default_nettype none
`timescale 1ns/1ps
module rtc_serial_port_slave_bench;
   import rtcsp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode = 1'b1;
   logic primaryBelowBattery = 1'b0;
   logic rechargeableBackup = 1'b0;
   logic writeLock = 1'b0;
   logic wrReady = 1'b1;
   logic selectIn, sclkIn, serialIn, serialOut, serialOutEn, wrValid;
   logic wrLockOnly, writeDropped, transferActive;
   logic [7:0] rdAddr, rdData, wrAddr, wrData;
   logic [16:0] got[$];
   int enHits = 0;
   int errors = 0;
   int nChecks = 0;
   always #25 clk = ~clk;
   // contents are a fixed function of the address
   assign rdData = rdAddr ^ 8'hC3;
   always @(posedge clk)
   begin
      if (wrValid === 1'b1 && wrReady) got.push_back({wrLockOnly, wrAddr, wrData});
      if (serialOutEn === 1'b1) enHits++;
   end
   rtcsp_serial_port i_dut (.clk, .rst_n, .selectIn, .sclkIn, .serialIn, .serialOut,
      .serialOutEn, .interfaceSelectPin(mode), .primaryBelowBattery, .rechargeableBackup,
      .writeLock, .rdAddr, .rdData, .wrValid, .wrAddr, .wrData, .wrLockOnly, .wrReady,
      .writeDropped, .transferActive);
   rtcsp_master i_mst (.clk, .threeWire(!mode), .dutOut(serialOut), .dutEn(serialOutEn),
      .sel(selectIn), .sck(sclkIn), .serial_in(serialIn));
   task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] seen);
      nChecks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp
   function automatic logic [7:0] nxt(input logic [7:0] p);
      case (p)
         8'h1F: return 8'h00;
         8'h7F: return 8'h20;
         8'h9F: return 8'h80;
         8'hFF: return 8'hA0;
         default: return p + 8'h01;
      endcase
   endfunction : nxt
   // ------
   // shared transfers
   // ------
   task automatic wr_burst(input logic [7:0] a, input int pol, three, stall, n, extra, nexp);
      logic [7:0] p;
      int k;
      p = a;
      i_mst.tx = {a};
      for (k = 0; k <= n; k++) i_mst.tx.push_back(a ^ 8'h5A ^ 8'(k));
      got.delete();
      enHits = 0;
      mode = three == 0;
      wrReady = stall == 0;
      i_mst.frame(pol[0], 8 + 8 * n + extra);
      if (stall != 0)
      begin
         cmp("dropped", 17'h1, {16'h0, writeDropped});
         wrReady = 1'b1;
      end
      repeat (12) @(negedge clk);
      cmp("outEn", 17'h0, 17'(enHits));
      cmp("empty", 17'h0, {16'h0, wrValid});
      cmp("writes", 17'(nexp), 17'(got.size()));
      for (k = 0; k < nexp; k++)
      begin
         cmp("write", {writeLock, p, a ^ 8'h5A ^ 8'(k)}, got[k]);
         p = nxt(p);
      end
   endtask : wr_burst
   task automatic rd_burst(input logic [7:0] a, input int pol, three);
      logic [7:0] p;
      int k;
      p = a;
      i_mst.tx = {a, 8'h00, 8'h00, 8'h00};
      mode = three == 0;
      i_mst.frame(pol[0], 32);
      cmp("reads", 17'h3, 17'(i_mst.rx.size()));
      for (k = 0; k < 3; k++)
      begin
         cmp("read", {9'h0, p ^ 8'hC3}, {9'h0, i_mst.rx[k]});
         p = nxt(p);
      end
   endtask : rd_burst
   // ------
   // scenarios
   // ------
   task automatic t_bursts;
      wr_burst(8'h9E, 1, 0, 0, 3, 0, 3);
      wr_burst(8'hFE, 0, 1, 0, 3, 0, 3);
      rd_burst(8'h1E, 0, 0);
      rd_burst(8'h7E, 1, 0);
      rd_burst(8'h1F, 0, 1);
   endtask : t_bursts
   task automatic t_abort;
      wr_burst(8'hA5, 0, 0, 0, 1, 5, 1);
   endtask : t_abort
   task automatic t_supply;
      primaryBelowBattery = 1'b1;
      wr_burst(8'h90, 0, 0, 0, 1, 0, 0);
      rd_burst(8'h40, 1, 0);
      rechargeableBackup = 1'b1;
      wr_burst(8'h91, 0, 0, 0, 1, 0, 1);
      primaryBelowBattery = 1'b0;
      rechargeableBackup = 1'b0;
   endtask : t_supply
   task automatic t_lock;
      writeLock = 1'b1;
      wr_burst(8'h85, 0, 0, 0, 1, 0, 0);
      wr_burst(8'h8F, 1, 0, 0, 1, 0, 1);
      writeLock = 1'b0;
   endtask : t_lock
   task automatic t_overflow;
      wr_burst(8'hA0, 0, 0, 1, 10, 0, 8);
      rd_burst(8'h00, 0, 0);
      cmp("dropClear", 17'h0, {16'h0, writeDropped});
   endtask : t_overflow
   task automatic wrap_up;
      if (errors == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      t_bursts();
      t_abort();
      t_supply();
      t_lock();
      t_overflow();
      wrap_up();
   end
   // about 190 us of traffic expected
   initial
   begin
      #2000000;
      errors++;
      wrap_up();
   end
endmodule : rtc_serial_port_slave_bench
`default_nettype wire
